// File: rtl/dbg_write_pkg.sv
// shared constants and types for the debug memory-write command block
// Overview of operation
// (R1) after the command the host sends a 32-bit target address then a data operand, and the block writes that data there.
// (R2) a byte write arrives as one 16-bit word and the block takes the byte from its low eight bits.
// (R3) a word write takes exactly one 16-bit data word and a longword write exactly two, high half first.
// (R4) a write that finishes cleanly answers 16'hffff with the status flag clear.
// (R5) a write that ends in a bus error answers 16'h0001 with the status flag set.
// (R6) after a clean write the start address plus the size (1, 2 or 4) is kept for a following fill command.
// (R7) no status is given until the system-bus write has completed or failed.
`default_nettype none
package dbg_write_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam logic [15:0] STATUS_OK = 16'hffff;
    localparam logic [15:0] STATUS_BERR = 16'h0001;
    localparam logic [1:0] ADDR_WORDS = 2'h2;
    localparam logic [1:0] DATA_WORDS_SHORT = 2'h1;
    localparam logic [1:0] DATA_WORDS_LONG = 2'h2;
    localparam logic [31:0] INC_BYTE = 32'h1;
    localparam logic [31:0] INC_WORD = 32'h2;
    localparam logic [31:0] INC_LONG = 32'h4;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_WORD = 2'b01,
        SIZE_LONG = 2'b10
    } op_size_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        op_size_type size;
    } bus_req_type;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic stat;
    } rsp_type;

    function automatic logic [31:0] size_inc(input op_size_type s);
        case (s)
            SIZE_BYTE: size_inc = INC_BYTE;
            SIZE_WORD: size_inc = INC_WORD;
            default: size_inc = INC_LONG;
        endcase
    endfunction

    function automatic logic [1:0] data_words(input op_size_type s);
        data_words = (s == SIZE_LONG) ? DATA_WORDS_LONG : DATA_WORDS_SHORT;
    endfunction
endpackage
`default_nettype wire

// File: rtl/word_pack.sv
// collects a given number of 16-bit words into one value, first word highest
`default_nettype none
module word_pack #(
    parameter int W = 16,
    parameter int N = 2
) (
    input wire logic clk_sys,              // system clock
    input wire logic rst_n,                // synchronous reset, active low
    input wire logic clr,                  // restart collection
    input wire logic in_valid,             // word strobe
    input wire logic [W-1:0] in_word,      // incoming word
    input wire logic [1:0] need,           // words to collect
    output logic [W*N-1:0] value_r,        // packed value
    output logic done_r                    // one-cycle pulse after last word
);
    logic [1:0] count_r;
    logic [1:0] count_nxt;

    assign count_nxt = count_r + 2'h1;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || clr) begin
            value_r <= '0;
            count_r <= 2'h0;
        end else if (in_valid) begin
            value_r <= {value_r[W*N-W-1:0], in_word};
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || clr) begin
            done_r <= 1'b0;
        end else begin
            done_r <= in_valid && (count_nxt == need);
        end
    end
endmodule // word_pack
`default_nettype wire

// File: rtl/dbg_mem_write.sv
// debug-port memory write command: gathers address and data, runs the bus write, answers status
`default_nettype none
module dbg_mem_write (
    input wire logic clk_sys,                            // system clock
    input wire logic rst_n,                              // synchronous reset, active low
    input wire logic cmd_start,                          // write command decoded, pulse
    input wire dbg_write_pkg::op_size_type cmd_size,     // operand size of the command
    input wire logic word_valid,                         // operand word shifted in, pulse
    input wire logic [15:0] word_data,                   // operand word
    output dbg_write_pkg::bus_req_type bus_r,            // system-bus write request fields
    output logic bus_req_r,                              // bus write requested, held to ack/error
    input wire logic bus_ack,                            // bus write completed, pulse
    input wire logic bus_err,                            // bus write ended in error, pulse
    output dbg_write_pkg::rsp_type rsp_r,                // status word and flag
    output logic rsp_valid_r,                            // status ready, pulse
    output logic [31:0] next_addr_r,                     // advanced address for fill
    output logic next_addr_valid_r,                      // next_addr_r may be used
    output logic busy_r                                  // command in progress
);
    import dbg_write_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10,
        ST_BUS = 2'b11
    } state_type;

    state_type state_r;
    op_size_type size_r;
    logic [31:0] addr_val;
    logic [31:0] data_val;
    logic addr_done;
    logic data_done;
    logic pack_clr;
    logic bus_end;
    logic [31:0] data_sized;

    assign pack_clr = (state_r == ST_IDLE) && cmd_start;
    assign bus_end = bus_req_r && (bus_ack || bus_err);

    word_pack #(.W(WORD_W), .N(2)) u_addr_pack (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clr(pack_clr),
        .in_valid(word_valid && (state_r == ST_ADDR) && !addr_done),
        .in_word(word_data),
        .need(ADDR_WORDS),
        .value_r(addr_val),
        .done_r(addr_done)
    ); // [R1]

    word_pack #(.W(WORD_W), .N(2)) u_data_pack (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clr(pack_clr),
        .in_valid(word_valid && (state_r == ST_DATA) && !data_done),
        .in_word(word_data),
        .need(data_words(size_r)),
        .value_r(data_val),
        .done_r(data_done)
    ); // [R3]

    // byte operand sits in the low eight bits of its word; upper bits are dropped
    always_comb begin
        case (size_r)
            SIZE_BYTE: data_sized = {24'h000000, data_val[7:0]}; // [R2]
            SIZE_WORD: data_sized = {16'h0000, data_val[15:0]};
            default: data_sized = data_val;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: if (cmd_start) state_r <= ST_ADDR;
                ST_ADDR: if (addr_done) state_r <= ST_DATA;
                ST_DATA: if (data_done) state_r <= ST_BUS;
                ST_BUS: if (bus_end) state_r <= ST_IDLE; // [R7]
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            size_r <= SIZE_BYTE;
            busy_r <= 1'b0;
        end else begin
            if (pack_clr) begin
                size_r <= cmd_size;
            end
            busy_r <= (state_r == ST_IDLE) ? cmd_start : !bus_end;
        end
    end

    // the request stays up until the bus answers; nothing is retried on error
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bus_req_r <= 1'b0;
            bus_r <= '0;
        end else if (state_r == ST_DATA && data_done) begin
            bus_req_r <= 1'b1; // [R1]
            bus_r.addr <= addr_val;
            bus_r.data <= data_sized;
            bus_r.size <= size_r;
        end else if (bus_end) begin
            bus_req_r <= 1'b0;
        end
    end

    // status only once the bus cycle has closed; an error wins over a same-cycle ack
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            rsp_valid_r <= bus_end; // [R7]
            if (bus_end && bus_err) begin
                rsp_r.word <= STATUS_BERR; // [R5]
                rsp_r.stat <= 1'b1;
            end else if (bus_end) begin
                rsp_r.word <= STATUS_OK; // [R4]
                rsp_r.stat <= 1'b0;
            end
        end
    end

    // a new write command invalidates the fill pointer until it completes cleanly
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            next_addr_r <= 32'h00000000;
            next_addr_valid_r <= 1'b0;
        end else if (bus_end && !bus_err) begin
            next_addr_r <= bus_r.addr + size_inc(bus_r.size); // [R6]
            next_addr_valid_r <= 1'b1;
        end else if (pack_clr || bus_end) begin
            next_addr_valid_r <= 1'b0;
        end
    end

    // helper: data words accepted during the current command
    logic [1:0] dwords_r;
    always_ff @(posedge clk_sys) begin
        if (!rst_n || pack_clr) begin
            dwords_r <= 2'h0;
        end else if (word_valid && state_r == ST_DATA && !data_done) begin
            dwords_r <= dwords_r + 2'h1;
        end
    end

    a_req_after_data: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
        $rose(bus_req_r) |-> $past(state_r == ST_DATA && data_done) && bus_r.addr == $past(addr_val))
        else $error("bus write not tied to gathered address");

    a_byte_low_bits: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
        $rose(bus_req_r) && bus_r.size == SIZE_BYTE |-> bus_r.data[31:8] == 24'h000000)
        else $error("byte write carries upper bits");

    a_data_word_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
        $rose(bus_req_r) |-> dwords_r == data_words(bus_r.size))
        else $error("wrong number of data words");

    a_ok_status_word: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
        rsp_valid_r && !rsp_r.stat |-> rsp_r.word == STATUS_OK && $past(bus_ack && !bus_err))
        else $error("clean write status wrong");

    a_err_status_word: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
        $past(bus_req_r && bus_err) |-> rsp_valid_r && rsp_r.stat && rsp_r.word == STATUS_BERR)
        else $error("bus error status wrong");

    a_next_addr_step: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
        bus_req_r && bus_ack && !bus_err |=> next_addr_valid_r && next_addr_r == bus_r.addr + size_inc(bus_r.size))
        else $error("fill address not advanced by size");

    a_status_after_bus: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
        rsp_valid_r |-> $past(bus_req_r) && !bus_req_r && $past(state_r) == ST_BUS)
        else $error("status before bus cycle closed");

    // request hold and status hand-off; the far side may stall for any number of cycles
    a_req_fields_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
        bus_req_r && !bus_end |=> bus_req_r && $stable(bus_r))
        else $error("request fields moved before the bus answered");

    a_req_in_bus: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
        bus_req_r |-> state_r == ST_BUS && busy_r)
        else $error("bus request outside the bus phase");

    a_req_drop_end: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
        bus_end |=> !bus_req_r && state_r == ST_IDLE && !busy_r)
        else $error("request or busy left up after bus answer");

    a_rsp_one_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
        rsp_valid_r |=> !rsp_valid_r)
        else $error("status strobe longer than one cycle");

    a_byte_from_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R2]
        $rose(bus_req_r) && bus_r.size == SIZE_BYTE |-> bus_r.data[7:0] == $past(data_val[7:0]))
        else $error("byte not taken from low bits of operand");

    a_size_held: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R3]
        state_r != ST_IDLE |=> $stable(size_r))
        else $error("operand size changed mid command");

    a_next_valid_rsp: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
        rsp_valid_r |-> next_addr_valid_r == !rsp_r.stat)
        else $error("fill pointer validity disagrees with status");

    a_cmd_clears_next: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
        pack_clr |=> !next_addr_valid_r)
        else $error("fill pointer still valid after new command");

    a_err_no_advance: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
        bus_req_r && bus_err |=> !next_addr_valid_r && rsp_r.stat)
        else $error("bus error advanced fill pointer or cleared flag");
endmodule // dbg_mem_write
`default_nettype wire

// File: dv/bus_slave.sv
// system-bus responder: answers each write request after a set wait, cleanly or with a bus error
`default_nettype none
module bus_slave (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic req, // write request level
    input wire logic [3:0] lat, // wait cycles before the answer
    input wire logic fail, // answer with a bus error
    output logic ack, // completion pulse
    output logic err // error pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r;
    // the pulse edge still sees req high, so a live pulse blocks a second answer
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !req || ack || err) begin
            cnt_r <= 4'h0;
            ack <= 1'b0;
            err <= 1'b0;
        end else if (cnt_r == lat) begin
            ack <= !fail;
            err <= fail;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule // bus_slave
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the debug memory-write command block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import dbg_write_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_start = 1'b0;
    logic word_valid = 1'b0;
    logic fail_sel = 1'b0;
    logic [3:0] lat_sel = 4'h0;
    logic [15:0] word_data = 16'h0;
    op_size_type cmd_size = SIZE_BYTE;
    bus_req_type bus_r;
    rsp_type rsp_r;
    logic bus_req_r, bus_ack, bus_err, rsp_valid_r, next_addr_valid_r, busy_r;
    logic [31:0] next_addr_r;
    int fails = 0;
    int num_checks = 0;

    dbg_mem_write u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_start(cmd_start), .cmd_size(cmd_size),
        .word_valid(word_valid), .word_data(word_data), .bus_r(bus_r), .bus_req_r(bus_req_r),
        .bus_ack(bus_ack), .bus_err(bus_err), .rsp_r(rsp_r), .rsp_valid_r(rsp_valid_r),
        .next_addr_r(next_addr_r), .next_addr_valid_r(next_addr_valid_r), .busy_r(busy_r));
    bus_slave u_slave (.clk_sys(clk_sys), .rst_n(rst_n), .req(bus_req_r), .lat(lat_sel),
        .fail(fail_sel), .ack(bus_ack), .err(bus_err));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task close_out;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // words are spaced three cycles apart, clear of the packer's dead cycle
    task send_word(input logic [15:0] w);
        @(posedge clk_sys);
        word_valid <= 1'b1;
        word_data <= w;
        @(posedge clk_sys);
        word_valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    task do_write(input op_size_type s, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] lat, input logic fail);
        logic [31:0] exp_d, inc;
        int n;
        exp_d = (s == SIZE_BYTE) ? {24'h0, d[7:0]} : (s == SIZE_WORD) ? {16'h0, d[15:0]} : d;
        inc = (s == SIZE_BYTE) ? INC_BYTE : (s == SIZE_WORD) ? INC_WORD : INC_LONG;
        @(posedge clk_sys);
        cmd_start <= 1'b1;
        cmd_size <= s;
        lat_sel <= lat;
        fail_sel <= fail;
        @(posedge clk_sys);
        cmd_start <= 1'b0;
        send_word(a[31:16]);
        send_word(a[15:0]);
        if (s == SIZE_LONG)
            send_word(d[31:16]);
        send_word(d[15:0]);
        #1;
        n = 0;
        while (bus_req_r !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 20) begin
                fails++;
                close_out;
            end
        end
        chk(bus_r.addr, a);
        chk(bus_r.data, exp_d);
        chk({30'h0, bus_r.size}, {30'h0, s});
        n = 0;
        while (rsp_valid_r !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 40) begin
                fails++;
                close_out;
            end
        end
        chk(32'(n), 32'(lat) + 32'h2);
        chk({15'h0, rsp_r.stat, rsp_r.word}, fail ? {16'h1, STATUS_BERR} : {16'h0, STATUS_OK});
        chk({31'h0, next_addr_valid_r}, {31'h0, !fail});
        if (!fail)
            chk(next_addr_r, a + inc);
    endtask

    // high byte carries junk that must not reach the bus
    task t_byte;
        do_write(SIZE_BYTE, 32'h2000_0101, 32'h0000_c35a, 4'h0, 1'b0);
        $display("byte write done");
    endtask

    task t_word;
        do_write(SIZE_WORD, 32'h2000_0102, 32'h0000_beef, 4'h3, 1'b0);
        $display("word write done");
    endtask

    // the advanced address wraps past the top of the map
    task t_long_wrap;
        do_write(SIZE_LONG, 32'hffff_fffc, 32'h1122_3344, 4'h6, 1'b0);
        $display("long write done");
    endtask

    task t_bus_error;
        do_write(SIZE_LONG, 32'h3000_0010, 32'h5566_7788, 4'h2, 1'b1);
        $display("bus error done");
    endtask

    // a word while idle must not shift the next command's operands
    task t_stray_word;
        send_word(16'h1234);
        do_write(SIZE_WORD, 32'h4000_0200, 32'h0000_0a0b, 4'h1, 1'b0);
        $display("stray word done");
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({29'h0, busy_r, bus_req_r, rsp_valid_r}, 32'h0);
        t_byte();
        t_word();
        t_long_wrap();
        t_bus_error();
        t_stray_word();
        close_out;
    end
endmodule // testbench
`default_nettype wire
